// ==== core/rsd_pkg.sv ====
// constants and types for the synthesiser core
package rsd_pkg;
    // register addresses on the host port
    localparam logic [7:0] ADDR_DIV_LOAD = 8'hB2;
    localparam logic [7:0] ADDR_CTRL = 8'hB3;
    localparam logic [7:0] ADDR_STATUS = 8'hB4;
    // counter widths and channel count
    localparam int N_W = 20;
    localparam int R_W = 13;
    localparam int NCH = 2;
    // control register: one byte per channel, channel 2 at +8
    localparam int CTL_CH_STRIDE = 8;
    localparam int CTL_EN = 0;
    localparam int CTL_SET = 1;
    localparam int CTL_TOL4 = 2;
    localparam int CTL_GAIN = 3;
    localparam int CTL_MASK = 4;
    localparam int CTL_REFSEL = 7;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // status register fields
    localparam int ST_LOCK = 0;
    localparam int ST_UNLOCK = 2;
    // data load words: 0 = N low, 1 = N high, 2 = R, 3 = commit
    localparam int LD_NLO_W = 14;
    localparam int LD_NHI_W = 6;
    localparam int LD_CH_BIT = 0;
    localparam int LD_SET_BIT = 1;
    // lock tolerances and error limit in reference cycles, lock history depth
    localparam logic [2:0] TOL_ONE = 3'h1;
    localparam logic [2:0] TOL_FOUR = 3'h4;
    localparam logic [2:0] ERR_MAX = 3'h7;
    localparam int HIST_LEN = 3;

    // division values of one set
    typedef struct packed {
        logic [N_W-1:0] n;
        logic [R_W-1:0] r;
    } rsd_div_t;

    // per-channel control fields
    typedef struct packed {
        logic irq_en;
        logic gain;
        logic tol4;
        logic set_b;
        logic en;
    } rsd_cfg_t;

    // data load sequence
    typedef enum logic [1:0] {LD_NLO, LD_NHI, LD_R, LD_COMMIT} rsd_ld_t;
endpackage

// ==== core/rsd_chan.sv ====
// one synthesiser channel: dividers, phase detector, lock detector
`timescale 1ns/1ps
module rsd_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_tick,
    input wire logic fb_tick,
    input rsd_pkg::rsd_cfg_t cfg,
    input rsd_pkg::rsd_div_t div,
    output logic cp_up,
    output logic cp_dn,
    output logic lock
);
    logic [rsd_pkg::R_W-1:0] r_cnt_r; // reference divider count
    logic [rsd_pkg::N_W-1:0] n_cnt_r; // feedback divider count
    logic r_pulse; // end of reference division cycle
    logic n_pulse; // end of feedback division cycle
    logic [2:0] err_r; // phase error in reference cycles
    logic [rsd_pkg::HIST_LEN-1:0] hist_r; // last lock samples
    logic good; // current sample within tolerance

    assign r_pulse = cfg.en && ref_tick && (r_cnt_r <= 13'h0001);
    assign n_pulse = cfg.en && fb_tick && (n_cnt_r <= 20'h00001);

    // reference divider, reload from active set each cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_cnt_r <= 13'h0000;
        else if (!cfg.en)
            r_cnt_r <= div.r;
        else if (r_pulse)
            r_cnt_r <= div.r;
        else if (ref_tick)
            r_cnt_r <= r_cnt_r - 13'h0001;
    end

    // feedback divider on the prescaled oscillator
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            n_cnt_r <= 20'h00000;
        else if (!cfg.en)
            n_cnt_r <= div.n;
        else if (n_pulse)
            n_cnt_r <= div.n;
        else if (fb_tick)
            n_cnt_r <= n_cnt_r - 20'h00001;
    end

    // phase-frequency detector; both high resets the pair
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cp_up <= 1'b0;
            cp_dn <= 1'b0;
        end
        else if (!cfg.en || (cp_up && cp_dn))
        begin
            cp_up <= 1'b0;
            cp_dn <= 1'b0;
        end
        else
        begin
            // reference ahead pumps up, feedback ahead pumps down
            cp_up <= cp_up | r_pulse;
            cp_dn <= cp_dn | n_pulse;
        end
    end

    // phase error width in undivided reference cycles, saturating
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            err_r <= 3'h0;
        else if (cp_up && cp_dn)
            err_r <= 3'h0;
        else if ((cp_up ^ cp_dn) && ref_tick && err_r != rsd_pkg::ERR_MAX)
            err_r <= err_r + 3'h1;
    end

    assign good = err_r <= (cfg.tol4 ? rsd_pkg::TOL_FOUR
                                     : rsd_pkg::TOL_ONE);

    // three-deep history, sampled at each detector reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hist_r <= 3'h0;
        else if (!cfg.en)
            hist_r <= 3'h0;
        else if (cp_up && cp_dn)
            hist_r <= {hist_r[1:0], good};
    end

    // majority vote: one stray miss does not drop lock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lock <= 1'b0;
        else
            lock <= (hist_r[0] & hist_r[1]) | (hist_r[0] & hist_r[2])
                  | (hist_r[1] & hist_r[2]);
    end
endmodule // rsd_chan

// ==== core/rsd_top.sv ====
// synthesiser core top: host registers, reference select, two channels
`timescale 1ns/1ps
module rsd_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic xtal_clk_in,
    input wire logic synth_ref_input,
    input wire logic [1:0] fb_in,
    output logic [1:0] cp_up,
    output logic [1:0] cp_dn,
    output logic [1:0] cp_hi_gain
);
    logic [15:0] ctrl_r; // control register
    rsd_pkg::rsd_div_t set_a_r [rsd_pkg::NCH]; // first division set
    rsd_pkg::rsd_div_t set_b_r [rsd_pkg::NCH]; // second division set
    rsd_pkg::rsd_ld_t ld_r; // data load position
    logic [rsd_pkg::LD_NLO_W-1:0] stg_nlo_r; // staged N low bits
    logic [rsd_pkg::LD_NHI_W-1:0] stg_nhi_r; // staged N high bits
    logic [rsd_pkg::R_W-1:0] stg_r_r; // staged R value
    logic [1:0] xt_s1_r; // crystal synchroniser, stage 1 and 2
    logic [1:0] rf_s1_r; // dedicated input synchroniser
    logic ref_d_r; // selected reference, previous value
    logic ref_tick; // one-cycle reference edge
    logic [1:0] fb_s1_r;
    logic [1:0] fb_s2_r;
    logic [1:0] fb_d_r;
    logic [1:0] lock; // majority-voted lock per channel
    logic [1:0] lock_d_r; // lock one cycle ago
    logic [1:0] unlock_r; // sticky loss-of-lock events
    logic [1:0] irq_mask;
    logic wr_data; // write to the data register
    logic wr_ctrl;
    logic rd_status;
    logic ref_now;

    // decode of the host port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign wr_data = reg_wr && hit(reg_addr, rsd_pkg::ADDR_DIV_LOAD);
    assign wr_ctrl = reg_wr && hit(reg_addr, rsd_pkg::ADDR_CTRL);
    assign rd_status = reg_rd && hit(reg_addr, rsd_pkg::ADDR_STATUS);

    // control register; fields act from the next clock, set select at the next divider reload
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= rsd_pkg::CTL_RESET;
        else if (wr_ctrl)
            ctrl_r <= reg_wdata;
    end

    // four-write load sequence; nothing reaches a set until commit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ld_r <= rsd_pkg::LD_NLO;
        else if (wr_data)
        begin
            case (ld_r)
                rsd_pkg::LD_NLO: ld_r <= rsd_pkg::LD_NHI;
                rsd_pkg::LD_NHI: ld_r <= rsd_pkg::LD_R;
                rsd_pkg::LD_R: ld_r <= rsd_pkg::LD_COMMIT;
                default: ld_r <= rsd_pkg::LD_NLO;
            endcase
        end
    end

    // staging of partial values
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stg_nlo_r <= 14'h0000;
            stg_nhi_r <= 6'h00;
            stg_r_r <= 13'h0000;
        end
        else if (wr_data)
        begin
            // the last word lands elsewhere, so only three cases here
            case (ld_r)
                rsd_pkg::LD_NLO: stg_nlo_r <= reg_wdata[13:0];
                rsd_pkg::LD_NHI: stg_nhi_r <= reg_wdata[5:0];
                rsd_pkg::LD_R: stg_r_r <= reg_wdata[12:0];
                default: stg_r_r <= stg_r_r;
            endcase
        end
    end

    // commit into one set of one channel; no interlock against live use
    genvar g;
    generate
        for (g = 0; g < rsd_pkg::NCH; g++)
        begin : g_set
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    set_a_r[g] <= '0;
                    set_b_r[g] <= '0;
                end
                else if (wr_data && ld_r == rsd_pkg::LD_COMMIT
                         && reg_wdata[rsd_pkg::LD_CH_BIT] == 1'(g))
                begin
                    // host keeps the live set untouched
                    if (reg_wdata[rsd_pkg::LD_SET_BIT])
                        set_b_r[g] <= {stg_nhi_r, stg_nlo_r, stg_r_r};
                    else
                        set_a_r[g] <= {stg_nhi_r, stg_nlo_r, stg_r_r};
                end
            end
        end
    endgenerate

    // pin inputs pass two flip-flops before any logic reads them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xt_s1_r <= 2'h0;
            rf_s1_r <= 2'h0;
            fb_s1_r <= 2'h0;
            fb_s2_r <= 2'h0;
        end
        else
        begin
            xt_s1_r <= {xt_s1_r[0], xtal_clk_in};
            rf_s1_r <= {rf_s1_r[0], synth_ref_input};
            fb_s1_r <= fb_in;
            fb_s2_r <= fb_s1_r;
        end
    end

    // one reference for both channels
    assign ref_now = ctrl_r[rsd_pkg::CTL_REFSEL] ? rf_s1_r[1]
                                                 : xt_s1_r[1];

    // edge detection of reference and feedback
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_d_r <= 1'b0;
            fb_d_r <= 2'h0;
        end
        else
        begin
            ref_d_r <= ref_now;
            fb_d_r <= fb_s2_r;
        end
    end

    assign ref_tick = ref_now & ~ref_d_r;

    // two identical channels; set labels carry no meaning
    generate
        for (g = 0; g < rsd_pkg::NCH; g++)
        begin : g_ch
            rsd_pkg::rsd_cfg_t cfg;
            logic [7:0] byte_c;
            assign byte_c = ctrl_r[g*rsd_pkg::CTL_CH_STRIDE +: 8];
            assign cfg.en = byte_c[rsd_pkg::CTL_EN];
            assign cfg.set_b = byte_c[rsd_pkg::CTL_SET];
            assign cfg.tol4 = byte_c[rsd_pkg::CTL_TOL4];
            assign cfg.gain = byte_c[rsd_pkg::CTL_GAIN];
            assign cfg.irq_en = byte_c[rsd_pkg::CTL_MASK];
            assign irq_mask[g] = cfg.irq_en;
            rsd_chan u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .ref_tick(ref_tick),
                .fb_tick(fb_s2_r[g] & ~fb_d_r[g]),
                .cfg(cfg),
                .div(cfg.set_b ? set_b_r[g] : set_a_r[g]),
                .cp_up(cp_up[g]),
                .cp_dn(cp_dn[g]),
                .lock(lock[g])
            );
            // pump current level, 4:1 between settings
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cp_hi_gain[g] <= 1'b0;
                else
                    cp_hi_gain[g] <= cfg.gain;
            end
        end
    endgenerate

    // loss-of-lock events; a new event beats a read-clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_d_r <= 2'h0;
            unlock_r <= 2'h0;
        end
        else
        begin
            lock_d_r <= lock;
            unlock_r <= (rd_status ? 2'h0 : unlock_r)
                      | (lock_d_r & ~lock);
        end
    end

    // interrupt only for unmasked events
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(unlock_r & irq_mask);
    end

    // read port; write-only and unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (rd_status)
            reg_rdata <= {12'h000, unlock_r, lock};
        else if (reg_rd)
            reg_rdata <= 16'h0000;
    end
endmodule // rsd_top

// ==== tb/rsd_top_properties.sv ====
// concurrent checks on the synthesiser core top ports
`timescale 1ns/1ps
module rsd_top_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic xtal_clk_in,
    input wire logic synth_ref_input,
    input wire logic [1:0] fb_in,
    input wire logic [1:0] cp_up,
    input wire logic [1:0] cp_dn,
    input wire logic [1:0] cp_hi_gain
);
    logic [15:0] ctl_r; // shadow of the control register
    logic wr_ctl; // control write taken this edge
    logic rd_st; // status read taken this edge
    assign wr_ctl = reg_wr && reg_addr == rsd_pkg::ADDR_CTRL;
    assign rd_st = reg_rd && reg_addr == rsd_pkg::ADDR_STATUS;
    // shadow follows writes; reset clears it as it clears the device
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_r <= 16'h0000;
        else if (wr_ctl)
            ctl_r <= reg_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a control write left alone for one cycle
    sequence s_ctl_write;
        wr_ctl ##1 !wr_ctl;
    endsequence
    // channel one disabled long enough to settle
    sequence s_ch1_off;
        (!ctl_r[0]) [*4];
    endsequence
    gain_follows_a:
    assert property (s_ctl_write |-> ##1 cp_hi_gain == {ctl_r[11], ctl_r[3]})
        else $error("pump gain differs from control bits");
    irq_masked_a:
    assert property ((!(ctl_r[4] || ctl_r[12])) [*3] |-> !irq)
        else $error("interrupt raised while masked");
    irq_read_clear_a:
    assert property (rd_st |-> ##[1:3] !irq)
        else $error("interrupt kept after status read");
    other_read_zero_a:
    assert property (reg_rd && !rd_st |-> ##1 reg_rdata == 16'h0000)
        else $error("write-only or unmapped read not zero");
    status_upper_a:
    assert property (rd_st |-> ##1 reg_rdata[15:4] == 12'h000)
        else $error("status unused bits set");
    pump1_clear_a:
    assert property (cp_up[0] && cp_dn[0] |=> !cp_up[0] && !cp_dn[0])
        else $error("pump one both sides held");
    pump2_clear_a:
    assert property (cp_up[1] && cp_dn[1] |=> !cp_up[1] && !cp_dn[1])
        else $error("pump two both sides held");
    pump_idle_off_a:
    assert property ((!ctl_r[0]) [*3] |-> !cp_up[0] && !cp_dn[0])
        else $error("pump one active while disabled");
    lock_off_a:
    assert property (s_ch1_off ##0 rd_st |-> ##1 !reg_rdata[0])
        else $error("lock shown on disabled channel");
endmodule // rsd_top_properties

bind rsd_top rsd_top_properties u_rsd_top_properties (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .xtal_clk_in(xtal_clk_in), .synth_ref_input(synth_ref_input),
    .fb_in(fb_in), .cp_up(cp_up), .cp_dn(cp_dn), .cp_hi_gain(cp_hi_gain)
);

// ==== tb/rsd_vco_model.sv ====
// ideal locked vco and loop filter seen through its prescaler
`timescale 1ns/1ps
module rsd_vco_model (
    input wire logic ref_clk,
    input wire logic [15:0] lag_ns,
    output logic [1:0] fb
);
    initial fb = 2'h0;
    // output tracks the reference at a settable lag (prompt or slow);
    // limitation: lag may only shrink while the channel is disabled
    always @(ref_clk)
    begin
        fb <= #(lag_ns) {2{ref_clk}};
    end
endmodule // rsd_vco_model

// ==== tb/tb_rf_synth_divider_lock.sv ====
// self-checking bench for the synthesiser core top
`timescale 1ns/1ps
module tb_rf_synth_divider_lock;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
        logic [1:0] gain;
    } rsd_row_t;
    // control rows and the gain each should give
    localparam rsd_row_t ROWS [5] = '{'{8'hB3, 16'h0008, 2'h1},
        '{8'hB3, 16'h0800, 2'h2}, '{8'hB3, 16'h0808, 2'h3},
        '{8'h10, 16'hFFFF, 2'h3}, '{8'hB3, 16'h0000, 2'h0}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtal = 1'b0; // reference, 8 clocks a period
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic [1:0] fb;
    logic [1:0] cp_up;
    logic [1:0] cp_dn;
    logic [1:0] cp_hi_gain;
    logic [15:0] lag_ns = 16'h000A; // vco lag
    logic [15:0] got;
    int err_total = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    always #100 xtal = ~xtal;
    rsd_top u_rsd_top (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .xtal_clk_in(xtal),
        .synth_ref_input(1'b0), .fb_in(fb), .cp_up(cp_up),
        .cp_dn(cp_dn), .cp_hi_gain(cp_hi_gain));
    rsd_vco_model u_rsd_vco_model (.ref_clk(xtal), .lag_ns(lag_ns), .fb(fb));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one write; idle cycle after so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // four data words; the last picks channel and set
    task automatic load(input logic [15:0] n, input logic [15:0] last);
        wr(rsd_pkg::ADDR_DIV_LOAD, n);
        wr(rsd_pkg::ADDR_DIV_LOAD, 16'h0000);
        wr(rsd_pkg::ADDR_DIV_LOAD, 16'h0008);
        wr(rsd_pkg::ADDR_DIV_LOAD, last);
    endtask
    // cold steps disable first so both dividers restart in phase
    task automatic step(input logic [15:0] ctl, input logic [15:0] lag,
                        input logic hot, input logic [15:0] exp_st,
                        input logic exp_irq);
        if (!hot)
        begin
            wr(rsd_pkg::ADDR_CTRL, ctl & 16'hFFFE);
            lag_ns = lag;
            repeat (40) @(negedge clk);
        end
        wr(rsd_pkg::ADDR_CTRL, ctl);
        // a hot lag step keeps the whole-cycle offset; a cold start would
        // realign both dividers and leave only the half-cycle remainder
        if (hot)
            lag_ns = lag;
        repeat (600) @(negedge clk);
        check("irq", {15'h0000, irq}, {15'h0000, exp_irq});
        rd(rsd_pkg::ADDR_STATUS, got);
        check("status", got, exp_st);
        check("irq cleared", {15'h0000, irq}, 16'h0000);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        foreach (ROWS[i])
        begin
            wr(ROWS[i].addr, ROWS[i].data);
            rd(ROWS[i].addr, got);
            check("readback", got, 16'h0000);
            check("gain", {14'h0000, cp_hi_gain}, {14'h0000, ROWS[i].gain});
        end
        // set A divides 8/8, set B 16/8 so it cannot lock
        load(16'h0008, 16'h0000);
        load(16'h0010, 16'h0002);
        step(16'h0011, 16'h000A, 1'b0, 16'h0001, 1'b0);
        step(16'h0013, 16'h000A, 1'b1, 16'h0004, 1'b1);
        step(16'h0011, 16'h000A, 1'b0, 16'h0001, 1'b0);
        // lag grown live gives two reference cycles of error
        step(16'h0015, 16'h01F4, 1'b1, 16'h0001, 1'b0);
        step(16'h0011, 16'h01F4, 1'b1, 16'h0004, 1'b1);
        step(16'h0001, 16'h000A, 1'b0, 16'h0001, 1'b0);
        step(16'h0001, 16'h01F4, 1'b1, 16'h0004, 1'b0);
        // mid-run reset with gain set: outputs and status clear
        wr(rsd_pkg::ADDR_CTRL, 16'h0809);
        repeat (4) @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check("rdata in reset", reg_rdata, 16'h0000);
        check("gain in reset", {14'h0000, cp_hi_gain}, 16'h0000);
        check("irq in reset", {15'h0000, irq}, 16'h0000);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check("gain after reset", {14'h0000, cp_hi_gain}, 16'h0000);
        rd(rsd_pkg::ADDR_STATUS, got);
        check("status after reset", got, 16'h0000);
        tally_and_finish();
    end
endmodule // tb_rf_synth_divider_lock
